/* logic/ssbs_top.sv */
`timescale 1ns/1ps
`include "ssbs_defines.svh"
module ssbs_top
    import ssbs_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // host command lines
    input wire logic MULTIFUNCTION_INPUT_A_I,
    input wire logic MULTIFUNCTION_INPUT_B_I,
    input wire logic START_STROBE_INPUT_I,
    input wire logic [5:0] POINT_SELECT_INPUTS_I,
    input wire logic [1:0] OP_KIND_I,
    // host status lines
    output logic IN_OPERATION_O,
    output logic POSITIONING_DONE_OUTPUT_O,
    output logic [5:0] POINT_POSITION_OUTPUTS_O
);

    // ======================================================================
    // helpers
    function automatic ssbs_stop_t decode_input(ssbs_func_t f, logic act);
        ssbs_stop_t s;
        s.estop = act && (f == FN_ESTOP);
        s.dstop = act && (f == FN_DSTOP);
        s.tstop = act && (f == FN_TSTOP);
        return s;
    endfunction

    function automatic logic reg_hit(logic [7:0] a);
        return (a == `SSBS_OFF_CTRL) || (a == `SSBS_OFF_EDEC) ||
               (a == `SSBS_OFF_SDEC) || (a == `SSBS_OFF_JDEC) ||
               (a == `SSBS_OFF_MOVE) || (a == `SSBS_OFF_MARK) ||
               (a == `SSBS_OFF_STAT);
    endfunction

    // ======================================================================
    // declarations
    ssbs_cfg_t cfg_q;
    logic [15:0] edec_q, sdec_q, jdec_q, move_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    ssbs_state_t state_q;
    ssbs_cause_t cause_q;
    ssbs_op_t op_q;
    logic [15:0] cnt_q, rem_q;
    logic [5:0] cur_pt_q, pos_q, pend_pt_q;
    logic pend_q, homed_q, inop_q, done_q, stb_q;
    logic [10:0] syn;
    logic in_a, in_b, stb, stb_rise, mark_rd, chain_ok, wr;
    logic [5:0] pt_sel, max_pt;
    ssbs_op_t kind_sel;
    ssbs_stop_t stop;
    logic [15:0] mv_load, op_dec;

    // ======================================================================
    // pin synchronisers
    ssbs_sync #(.W(11)) u_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i({OP_KIND_I, POINT_SELECT_INPUTS_I, START_STROBE_INPUT_I,
              MULTIFUNCTION_INPUT_B_I, MULTIFUNCTION_INPUT_A_I}),
        .q_o(syn)
    );

    assign in_a = syn[0] ^ cfg_q.input_a_polarity;
    assign in_b = syn[1] ^ cfg_q.input_b_polarity;
    assign stb = syn[2];
    assign pt_sel = syn[8:3];
    assign kind_sel = ssbs_op_t'(syn[10:9]);
    assign stb_rise = stb && !stb_q;
    // both inputs merged so either may carry any function
    assign stop = decode_input(cfg_q.input_a_function_select, in_a) |
                  decode_input(cfg_q.input_b_function_select, in_b);

    // ======================================================================
    // derived values
    assign max_pt = 6'((`SSBS_PT_BASE << cfg_q.point_count_select) - 7'h01);
    // a zero move time would outrun the one-cycle mark read
    assign mv_load = (move_q < `SSBS_MIN_MOVE) ? `SSBS_MIN_MOVE : move_q;
    assign op_dec = (op_q == OP_STEP) ? sdec_q : jdec_q;
    assign chain_ok = (op_q == OP_STEP) && mark_rd &&
                      (cur_pt_q != max_pt);

    // ======================================================================
    // block marks
    assign wr = PSEL_I && PENABLE_I && PWRITE_I && pready_q;

    ssbs_mark_mem u_mark (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .we_i(wr && (PADDR_I == `SSBS_OFF_MARK)),
        .waddr_i(PWDATA_I[5:0]),
        .wdata_i(PWDATA_I[`SSBS_MARK_BIT]),
        .raddr_i(cur_pt_q),
        .rdata_o(mark_rd)
    );

    // ======================================================================
    // apb register writes
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cfg_q <= ssbs_cfg_t'(`SSBS_CTRL_RST);
            edec_q <= `SSBS_TIME_RST;
            sdec_q <= `SSBS_TIME_RST;
            jdec_q <= `SSBS_TIME_RST;
            move_q <= `SSBS_TIME_RST;
        end else if (wr) begin
            if (PADDR_I == `SSBS_OFF_CTRL) begin
                cfg_q <= ssbs_cfg_t'(PWDATA_I[`SSBS_CTRL_W-1:0]);
            end else if (PADDR_I == `SSBS_OFF_EDEC) begin
                edec_q <= PWDATA_I[15:0];
            end else if (PADDR_I == `SSBS_OFF_SDEC) begin
                sdec_q <= PWDATA_I[15:0];
            end else if (PADDR_I == `SSBS_OFF_JDEC) begin
                jdec_q <= PWDATA_I[15:0];
            end else if (PADDR_I == `SSBS_OFF_MOVE) begin
                move_q <= PWDATA_I[15:0];
            end
        end
    end

    // ======================================================================
    // apb answer: always one access cycle, data set up in the setup cycle
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I) begin
            pready_q <= 1'b1;
            pslverr_q <= !reg_hit(PADDR_I);
            if (PADDR_I == `SSBS_OFF_CTRL) begin
                prdata_q <= {22'h00_0000, cfg_q};
            end else if (PADDR_I == `SSBS_OFF_EDEC) begin
                prdata_q <= {16'h0000, edec_q};
            end else if (PADDR_I == `SSBS_OFF_SDEC) begin
                prdata_q <= {16'h0000, sdec_q};
            end else if (PADDR_I == `SSBS_OFF_JDEC) begin
                prdata_q <= {16'h0000, jdec_q};
            end else if (PADDR_I == `SSBS_OFF_MOVE) begin
                prdata_q <= {16'h0000, move_q};
            end else if (PADDR_I == `SSBS_OFF_STAT) begin
                prdata_q <= {13'h0000, state_q, cause_q, pend_q, homed_q,
                             pos_q, cur_pt_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ======================================================================
    // stop and block sequencer
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            cause_q <= CZ_NORMAL;
            op_q <= OP_STEP;
            cnt_q <= 16'h0000;
            rem_q <= 16'h0000;
            cur_pt_q <= `SSBS_PT_RST;
            pos_q <= `SSBS_PT_RST;
            pend_pt_q <= `SSBS_PT_RST;
            pend_q <= 1'b0;
            homed_q <= 1'b0;
            inop_q <= 1'b1;
            stb_q <= 1'b0;
        end else begin
            stb_q <= stb;
            case (state_q)
                ST_IDLE: begin
                    if (stop.estop || stop.dstop) begin
                        pend_q <= 1'b0;
                    end else if (pend_q && !stop.tstop) begin
                        pend_q <= 1'b0;
                        op_q <= OP_STEP;
                        cur_pt_q <= pend_pt_q;
                        cnt_q <= mv_load;
                        inop_q <= 1'b0;
                        state_q <= ST_RUN;
                    end else if (stb_rise && stop.tstop) begin
                        // jog and homing starts are ignored while the temporary stop is held
                        if (kind_sel == OP_STEP) begin
                            pend_q <= 1'b1;
                            pend_pt_q <= pt_sel;
                        end
                    end else if (stb_rise) begin
                        op_q <= kind_sel;
                        cur_pt_q <= pt_sel;
                        cnt_q <= mv_load;
                        inop_q <= 1'b0;
                        if (kind_sel == OP_HOME) begin
                            homed_q <= 1'b0;
                        end
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (stop.estop) begin
                        cause_q <= CZ_ESTOP;
                        cnt_q <= edec_q;
                        if (edec_q == 16'h0000) begin
                            inop_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_DECEL;
                        end
                    end else if (stop.dstop ||
                                 (stop.tstop && op_q != OP_STEP)) begin
                        cause_q <= CZ_DSTOP;
                        cnt_q <= op_dec;
                        state_q <= ST_DECEL;
                    end else if (stop.tstop) begin
                        cause_q <= CZ_TEMP;
                        rem_q <= cnt_q;
                        cnt_q <= op_dec;
                        state_q <= ST_DECEL;
                    end else if (op_q == OP_JOG) begin
                        if (!stb) begin
                            cause_q <= CZ_NORMAL;
                            cnt_q <= op_dec;
                            state_q <= ST_DECEL;
                        end
                    end else if (cnt_q == 16'h0000) begin
                        // combined mode rolls on without stopping
                        if (cfg_q.block_mode_select && chain_ok) begin
                            cur_pt_q <= cur_pt_q + 6'h01;
                            cnt_q <= mv_load;
                        end else begin
                            cause_q <= CZ_NORMAL;
                            cnt_q <= op_dec;
                            state_q <= ST_DECEL;
                        end
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_DECEL: begin
                    if (stop.estop && cause_q != CZ_ESTOP) begin
                        inop_q <= 1'b1;
                        pend_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (stop.dstop && cause_q == CZ_TEMP) begin
                        cause_q <= CZ_DSTOP;
                    end else if (cnt_q != 16'h0000) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end else if (cause_q == CZ_TEMP) begin
                        if (stop.tstop) begin
                            state_q <= ST_PAUSE;
                        end else begin
                            cnt_q <= rem_q;
                            state_q <= ST_RUN;
                        end
                    end else if (cause_q == CZ_NORMAL) begin
                        if (!cfg_q.block_mode_select && chain_ok) begin
                            cur_pt_q <= cur_pt_q + 6'h01;
                            cnt_q <= mv_load;
                            state_q <= ST_RUN;
                        end else begin
                            state_q <= ST_DONE;
                        end
                    end else begin
                        inop_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_PAUSE: begin
                    if (stop.estop || stop.dstop) begin
                        inop_q <= 1'b1;
                        pend_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (!stop.tstop) begin
                        cnt_q <= rem_q;
                        state_q <= ST_RUN;
                    end
                end
                ST_DONE: begin
                    if (!stb) begin
                        pos_q <= cur_pt_q;
                        inop_q <= 1'b1;
                        if (op_q == OP_HOME) begin
                            homed_q <= 1'b1;
                        end
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // shared status pin
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            done_q <= 1'b1;
        end else if (cfg_q.status_output_select) begin
            done_q <= (state_q == ST_DECEL);
        end else begin
            done_q <= (state_q == ST_IDLE) || (state_q == ST_PAUSE) ||
                      (state_q == ST_DONE);
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign IN_OPERATION_O = inop_q;
    assign POSITIONING_DONE_OUTPUT_O = done_q;
    assign POINT_POSITION_OUTPUTS_O = pos_q;

    // ======================================================================
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    property p_estop_first;
        state_q == ST_RUN && stop.estop && stop.dstop |=>
            state_q == ST_IDLE || cause_q == CZ_ESTOP;
    endproperty
    a_estop_first: assert property (p_estop_first)
        else $error("estop lost priority");

    property p_strobe_ignored;
        state_q == ST_IDLE && (stop.estop || stop.dstop) && stb_rise |=>
            state_q == ST_IDLE && !pend_q;
    endproperty
    a_strobe_ignored: assert property (p_strobe_ignored)
        else $error("strobe accepted during stop");

    property p_decel_holds;
        state_q == ST_DECEL && cause_q == CZ_DSTOP && cnt_q != 16'h0000 &&
            !stop.estop |=> state_q == ST_DECEL && cnt_q == $past(cnt_q) - 1;
    endproperty
    a_decel_holds: assert property (p_decel_holds)
        else $error("decel-stop cut short");

    property p_estop_in_dstop;
        state_q == ST_DECEL && cause_q == CZ_DSTOP && stop.estop |=>
            state_q == ST_IDLE && inop_q;
    endproperty
    a_estop_in_dstop: assert property (p_estop_in_dstop)
        else $error("estop did not stop at once");

    property p_estop_in_temp;
        state_q == ST_DECEL && cause_q == CZ_TEMP && stop.estop |=>
            state_q == ST_IDLE;
    endproperty
    a_estop_in_temp: assert property (p_estop_in_temp)
        else $error("estop during temp decel not immediate");

    property p_pause_busy;
        state_q == ST_PAUSE |-> !inop_q;
    endproperty
    a_pause_busy: assert property (p_pause_busy)
        else $error("in-operation on while paused");

    property p_pos_held;
        state_q == ST_DECEL && cause_q != CZ_NORMAL |=> $stable(pos_q);
    endproperty
    a_pos_held: assert property (p_pos_held)
        else $error("position moved during stop");

    property p_resume;
        state_q == ST_PAUSE && !stop.estop && !stop.dstop && !stop.tstop
            |=> state_q == ST_RUN && cnt_q == $past(rem_q);
    endproperty
    a_resume: assert property (p_resume)
        else $error("pause did not resume");

    property p_temp_on_jog;
        state_q == ST_RUN && op_q == OP_JOG && stop.tstop && !stop.estop
            |=> state_q == ST_DECEL && cause_q == CZ_DSTOP;
    endproperty
    a_temp_on_jog: assert property (p_temp_on_jog)
        else $error("temp stop paused a jog");

    property p_estop_zero;
        state_q == ST_RUN && stop.estop && edec_q == 16'h0000 |=>
            state_q == ST_IDLE ##1 done_q || cfg_q.status_output_select;
    endproperty
    a_estop_zero: assert property (p_estop_zero)
        else $error("zero estop time not immediate");

endmodule // ssbs_top

/* logic/ssbs_defines.svh */
`ifndef SSBS_DEFINES_SVH
`define SSBS_DEFINES_SVH

// ==========================================================================
// register offsets (byte addresses)
`define SSBS_OFF_CTRL 8'h00
`define SSBS_OFF_EDEC 8'h04
`define SSBS_OFF_SDEC 8'h08
`define SSBS_OFF_JDEC 8'h0C
`define SSBS_OFF_MOVE 8'h10
`define SSBS_OFF_MARK 8'h14
`define SSBS_OFF_STAT 8'h18

// ==========================================================================
// field widths and positions
`define SSBS_CTRL_W 10
`define SSBS_TIME_W 16
`define SSBS_PT_W 6
`define SSBS_MARK_BIT 8

// ==========================================================================
// reset values
`define SSBS_CTRL_RST 10'h000
`define SSBS_TIME_RST 16'h0010
`define SSBS_PT_RST 6'h00

// ==========================================================================
// counts
`define SSBS_PT_BASE 7'h08
`define SSBS_MIN_MOVE 16'h0001
`define SSBS_MARK_DEPTH 64

`endif

/* logic/ssbs_pkg.sv */
package ssbs_pkg;

    // ======================================================================
    // function assigned to a multifunction input
    typedef enum logic [1:0] {FN_NONE, FN_ESTOP, FN_DSTOP, FN_TSTOP}
        ssbs_func_t;

    // ======================================================================
    // operation started by the strobe
    typedef enum logic [1:0] {OP_STEP, OP_JOG, OP_HOME, OP_SPARE}
        ssbs_op_t;

    // ======================================================================
    // why the axis is decelerating
    typedef enum logic [1:0] {CZ_NORMAL, CZ_TEMP, CZ_DSTOP, CZ_ESTOP}
        ssbs_cause_t;

    // ======================================================================
    // sequencer states
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_PAUSE, ST_DONE}
        ssbs_state_t;

    // ======================================================================
    // configuration word, input_a function in the low bits
    typedef struct packed {
        logic [1:0] point_count_select;
        logic block_mode_select;
        logic status_output_select;
        logic input_b_polarity;
        logic input_a_polarity;
        ssbs_func_t input_b_function_select;
        ssbs_func_t input_a_function_select;
    } ssbs_cfg_t;

    // ======================================================================
    // merged stop requests
    typedef struct packed {
        logic estop;
        logic dstop;
        logic tstop;
    } ssbs_stop_t;

endpackage

/* logic/ssbs_sync.sv */
`timescale 1ns/1ps
module ssbs_sync #(
    parameter int W = 11
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins and synchronised copy
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // ======================================================================
    // two flops per bit; the first is read by the second only
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= d_i[g];
                    sync_q <= meta_q;
                end
            end
            assign q_o[g] = sync_q;
        end
    endgenerate

endmodule // ssbs_sync

/* logic/ssbs_mark_mem.sv */
`timescale 1ns/1ps
`include "ssbs_defines.svh"
module ssbs_mark_mem
    import ssbs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // write port
    input wire logic we_i,
    input wire logic [5:0] waddr_i,
    input wire logic wdata_i,
    // read port, one cycle latency
    input wire logic [5:0] raddr_i,
    output logic rdata_o
);

    // ======================================================================
    // block marks, one bit per point; contents undefined until written
    logic mem_q [`SSBS_MARK_DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 1'b0;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end

endmodule // ssbs_mark_mem

/* sim/ssbs_host.sv */
`timescale 1ns/1ps
module ssbs_host (
    // clock
    input wire logic clk_i,
    // command lines
    output logic in_a_o,
    output logic in_b_o,
    output logic stb_o,
    output logic [5:0] pt_o,
    output logic [1:0] kind_o
);
    // ==================================
    // host lines; kind set apart from the strobe
    initial {in_a_o, in_b_o, stb_o, pt_o, kind_o} = 11'h000;
    // callers drop strobe after busy falls, or while a stop still holds the start off
    // a new strobe may rise while a stop is still held
    task drive(input logic [2:0] s, input logic [5:0] p);
        @(posedge clk_i);
        {in_a_o, in_b_o, stb_o} <= s;
        pt_o <= p;
    endtask
    // kind changes one edge ahead of the strobe
    task set_kind(input logic [1:0] k);
        @(posedge clk_i);
        kind_o <= k;
    endtask
endmodule // ssbs_host

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "ssbs_defines.svh"
module testbench;
    // ==================================
    // bench state
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pad = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic rdy, err, se, a, b, stb, busy, done;
    logic [5:0] pt, pos;
    logic [1:0] kind;
    int errors = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    ssbs_top i_ssbs_top (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pad), .PWDATA_I(pwd),
        .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
        .MULTIFUNCTION_INPUT_A_I(a), .MULTIFUNCTION_INPUT_B_I(b),
        .START_STROBE_INPUT_I(stb), .POINT_SELECT_INPUTS_I(pt),
        .OP_KIND_I(kind), .IN_OPERATION_O(busy),
        .POSITIONING_DONE_OUTPUT_O(done), .POINT_POSITION_OUTPUTS_O(pos));
    ssbs_host i_ssbs_host (.clk_i(clk), .in_a_o(a), .in_b_o(b),
        .stb_o(stb), .pt_o(pt), .kind_o(kind));
    task test_done;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // apb master; no fixed latency assumed
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pad <= ad;
        pwd <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
            test_done;
        end
        rd = prd;
        se = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // bounded wait on done (s=1) or busy (s=0)
    task wt(input logic s, input logic v);
        int n;
        n = 0;
        while ((s ? done : busy) !== v && n < 500) begin
            @(posedge clk);
            n++;
        end
        if ((s ? done : busy) !== v) begin
            chk("wait", {31'h0, v}, {31'h0, ~v});
            test_done;
        end
    endtask
    task s_reg;
        apb(1'b0, `SSBS_OFF_STAT, 32'h0);
        chk("stat", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, se});
        apb(1'b1, `SSBS_OFF_CTRL, 32'h0000000D);
        apb(1'b0, `SSBS_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0000000D, rd);
        apb(1'b1, `SSBS_OFF_EDEC, 32'h0);
        apb(1'b1, `SSBS_OFF_MARK, 32'h3);
        apb(1'b1, `SSBS_OFF_MARK, 32'h5);
    endtask
    task s_step;
        i_ssbs_host.drive(3'b001, 6'h03);
        wt(1'b0, 1'b0);
        repeat (2) @(posedge clk);
        wt(1'b1, 1'b1);
        chk("busy", 32'h0, {31'h0, busy});
        i_ssbs_host.drive(3'b000, 6'h03);
        wt(1'b0, 1'b1);
        chk("pos", 32'h3, {26'h0, pos});
    endtask
    task s_estop;
        i_ssbs_host.drive(3'b001, 6'h05);
        wt(1'b0, 1'b0);
        i_ssbs_host.drive(3'b100, 6'h05);
        wt(1'b0, 1'b1);
        chk("pos", 32'h3, {26'h0, pos});
        i_ssbs_host.drive(3'b101, 6'h05);
        repeat (8) @(posedge clk);
        chk("busy", 32'h1, {31'h0, busy});
        i_ssbs_host.drive(3'b000, 6'h05);
    endtask
    task s_tstop;
        i_ssbs_host.drive(3'b001, 6'h05);
        wt(1'b0, 1'b0);
        i_ssbs_host.drive(3'b011, 6'h05);
        repeat (4) @(posedge clk);
        wt(1'b1, 1'b1);
        chk("busy", 32'h0, {31'h0, busy});
        i_ssbs_host.drive(3'b001, 6'h05);
        wt(1'b1, 1'b0);
        wt(1'b1, 1'b1);
        i_ssbs_host.drive(3'b000, 6'h05);
        wt(1'b0, 1'b1);
        chk("pos", 32'h5, {26'h0, pos});
    endtask
    // input a decel-stop, input b estop, status pin shows decel
    task s_dstop;
        apb(1'b1, `SSBS_OFF_CTRL, 32'h00000046);
        apb(1'b1, `SSBS_OFF_EDEC, 32'h00000020);
        i_ssbs_host.drive(3'b001, 6'h05);
        wt(1'b0, 1'b0);
        i_ssbs_host.drive(3'b100, 6'h05);
        wt(1'b1, 1'b1);
        i_ssbs_host.drive(3'b110, 6'h05);
        repeat (5) @(posedge clk);
        chk("busy", 32'h1, {31'h0, busy});
        chk("decel", 32'h0, {31'h0, done});
        i_ssbs_host.drive(3'b000, 6'h05);
        i_ssbs_host.drive(3'b001, 6'h05);
        wt(1'b0, 1'b0);
        i_ssbs_host.drive(3'b110, 6'h05);
        wt(1'b1, 1'b1);
        i_ssbs_host.drive(3'b000, 6'h05);
        apb(1'b0, `SSBS_OFF_STAT, 32'h0);
        chk("state", 32'h0000000B, {27'h0, rd[18:14]});
        wt(1'b0, 1'b1);
        chk("pos", 32'h5, {26'h0, pos});
    endtask
    // input a temporary stop: jog cancelled, step strobe held
    task s_jog;
        apb(1'b1, `SSBS_OFF_CTRL, 32'h00000003);
        i_ssbs_host.set_kind(2'h1);
        i_ssbs_host.drive(3'b001, 6'h05);
        wt(1'b0, 1'b0);
        i_ssbs_host.drive(3'b101, 6'h05);
        wt(1'b0, 1'b1);
        i_ssbs_host.drive(3'b100, 6'h05);
        i_ssbs_host.set_kind(2'h0);
        i_ssbs_host.drive(3'b101, 6'h03);
        repeat (6) @(posedge clk);
        chk("busy", 32'h1, {31'h0, busy});
        apb(1'b0, `SSBS_OFF_STAT, 32'h0);
        chk("pend", 32'h1, {31'h0, rd[13]});
        i_ssbs_host.drive(3'b000, 6'h03);
        wt(1'b0, 1'b0);
        wt(1'b0, 1'b1);
        chk("pos", 32'h3, {26'h0, pos});
    endtask
    // point 6 chains to point 7, the highest, which ends the chain
    task s_block;
        apb(1'b1, `SSBS_OFF_MARK, 32'h00000106);
        apb(1'b1, `SSBS_OFF_MARK, 32'h00000107);
        i_ssbs_host.drive(3'b001, 6'h06);
        wt(1'b0, 1'b0);
        repeat (2) @(posedge clk);
        wt(1'b1, 1'b1);
        chk("busy", 32'h0, {31'h0, busy});
        i_ssbs_host.drive(3'b000, 6'h06);
        wt(1'b0, 1'b1);
        chk("pos", 32'h7, {26'h0, pos});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        s_reg;
        s_step;
        s_estop;
        s_tstop;
        s_dstop;
        s_jog;
        s_block;
        test_done;
    end
endmodule // testbench
